// ---- src/shti_irq.sv ----
// What this block does
// - no line or message while global enable clear
// - global enable masks outputs and clears pending messages
// - status bits set regardless of enables
// - summary register is 32 bits, one per port
// - status AND enable OR-reduced sets summary
// - summary bit clears only on written one
// - still-high virtual wire resets summary at once
// - summary mode when msi off or mme zero
// - wire mode drives line low while any set
// - single msi sends on nonzero summary change
// - capable field is power of two over ports
// - multi mode ignores summary for sending
// - global enable gates multi mode messages
// - ports map one-to-one, max 16 messages
// - three per-port triggers in multi mode
// - request covers highest summary bit used
// - port n uses message n when enough
// - sharing clears revert flag, last shared
// - sharers evaluated together per message
// - fallback sets revert flag, single rules
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`include "shti_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module shti_irq
  import shti_pkg::*;
#(
  parameter int                   NPORTS    = 6,
  parameter logic [31:0]          PI_MAP    = 32'h0000_003F,
  parameter bit                   SHARE_LAST = 1'b1
) (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  // per-port status events, one pulse bit per cause
  input  wire logic [NPORTS*8-1:0] i_port_event,
  // axi4-lite write address
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // interrupt outputs
  output logic                    o_int_line_n,
  output shti_msg_t               o_msi
);
  localparam logic [31:0] IMPL = PI_MAP & ((NPORTS >= 32) ? 32'hFFFF_FFFF
                                 : ((32'h1 << NPORTS) - 32'h1));

  // smallest power of two covering the highest used bit
  function automatic logic [2:0] log2_cover(input int n);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 0; k < 6; k++)
      if ((1 << k) < n) r = 3'(k + 1);
    return r;
  endfunction
  localparam logic [2:0] MMC = log2_cover(NPORTS);
  localparam int NMSG_REQ = 1 << MMC;

  // registers
  logic [NPORTS*8-1:0] stat_q;
  logic [NPORTS*8-1:0] en_q;
  logic [31:0]         sum_q;
  logic                gie_q;
  logic                msie_q;
  logic [2:0]          mme_q;
  logic [4:0]          psel_q;

  // bus handshake state
  logic                aw_got_q, w_got_q;
  logic [7:0]          awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;

  // virtual wires, one per port
  logic [31:0] vwire;
  always_comb begin
    vwire = 32'h0;
    for (int p = 0; p < NPORTS; p++)
      vwire[p] = |(stat_q[p*8 +: 8] & en_q[p*8 +: 8]);
  end

  // decode of the mode and revert decision
  logic [4:0]  granted;
  logic        fewer, mrsm, multi;
  shti_mode_t  mode;
  always_comb begin
    granted = 5'(1 << mme_q);
    fewer   = msie_q && (mme_q != `SHTI_RST_MME) && (mme_q < MMC);
    mrsm    = fewer && !SHARE_LAST;
    multi   = msie_q && (mme_q != `SHTI_RST_MME) && !mrsm;
    if (!msie_q)    mode = SHTI_MODE_WIRE;
    else if (multi) mode = SHTI_MODE_MULTI;
    else            mode = SHTI_MODE_SINGLE;
  end

  // write channel acceptance
  logic wr_fire, wr_hit;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  function automatic logic [31:0] lane(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction
  logic [31:0] wmask;
  assign wmask = lane(32'h0, 32'hFFFF_FFFF, wstrb_q);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      w_got_q <= 1'b0;
      wdata_q <= `SHTI_RST_WORD;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
    end
  end
  assign wr_hit = (awaddr_q == `SHTI_OFF_GHC) ||
                  (awaddr_q == `SHTI_OFF_SUMMARY) ||
                  (awaddr_q == `SHTI_OFF_MSICFG) ||
                  (awaddr_q == `SHTI_OFF_PSTAT) ||
                  (awaddr_q == `SHTI_OFF_PEN) ||
                  (awaddr_q == `SHTI_OFF_PSEL);
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10; // slverr when unmapped
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // global control: enable, msi configuration and port select
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gie_q  <= 1'b0;
      msie_q <= 1'b0;
      mme_q  <= `SHTI_RST_MME;
      psel_q <= 5'h00;
    end else if (wr_fire) begin
      if (awaddr_q == `SHTI_OFF_GHC && wstrb_q[0])
        gie_q <= wdata_q[`SHTI_GLOBAL_INT_ENABLE];
      if (awaddr_q == `SHTI_OFF_MSICFG && wstrb_q[0]) begin
        msie_q <= wdata_q[`SHTI_MC_MSIE];
        mme_q  <= wdata_q[`SHTI_MC_MME_LSB +: 3];
      end
      if (awaddr_q == `SHTI_OFF_PSEL && wstrb_q[0])
        psel_q <= wdata_q[4:0];
    end
  end

  // per-port status is w1c; a new event wins over a clear
  logic [NPORTS*8-1:0] stat_d, en_d;
  always_comb begin
    stat_d = stat_q;
    en_d   = en_q;
    for (int p = 0; p < NPORTS; p++) begin
      if (wr_fire && psel_q == 5'(p)) begin
        if (awaddr_q == `SHTI_OFF_PSTAT)
          stat_d[p*8 +: 8] = stat_q[p*8 +: 8] & ~(wdata_q[7:0] & wmask[7:0]);
        if (awaddr_q == `SHTI_OFF_PEN && wstrb_q[0])
          en_d[p*8 +: 8] = wdata_q[7:0];
      end
    end
    stat_d = stat_d | i_port_event;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stat_q <= '0;
      en_q   <= '0;
    end else begin
      stat_q <= stat_d;
      en_q   <= en_d;
    end
  end

  // summary: sticky, w1c, re-set by a still-high wire
  logic [31:0] sum_d;
  always_comb begin
    sum_d = sum_q;
    if (wr_fire && awaddr_q == `SHTI_OFF_SUMMARY)
      sum_d = sum_q & ~(wdata_q & wmask);
    sum_d = (sum_d | vwire) & IMPL;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) sum_q <= `SHTI_RST_WORD;
    else         sum_q <= sum_d;
  end

  // per-message triggers for multi mode, sharers or-ed together
  logic [NPORTS*8-1:0] prev_act_q;
  logic [NPORTS*8-1:0] prev_stat_q;
  logic [NPORTS*8-1:0] act;
  logic [15:0]         msg_trig;
  logic [3:0]          last_msg;
  assign act = stat_q & en_q;
  always_comb begin
    logic [3:0]  m;
    logic [15:0] grp_new, grp_clr, grp_act;
    m        = 4'h0;
    grp_new  = 16'h0;
    grp_clr  = 16'h0;
    grp_act  = 16'h0;
    last_msg = 4'((fewer ? granted : 5'(NMSG_REQ)) - 5'h1);
    for (int p = 0; p < NPORTS; p++) begin
      if (IMPL[p]) begin
        m = (p > int'(last_msg)) ? last_msg : 4'(p);
        // new enabled bit, or an enable rising over a set bit
        grp_new[m] = grp_new[m] |
                     (|(act[p*8 +: 8] & ~prev_act_q[p*8 +: 8]));
        // any status bit cleared, enabled or not
        grp_clr[m] = grp_clr[m] |
                     (|(prev_stat_q[p*8 +: 8] & ~stat_q[p*8 +: 8]));
        grp_act[m] = grp_act[m] | (|act[p*8 +: 8]);
      end
    end
    // sharers judged as one: a clear fires while any sharer is pending
    msg_trig = grp_new | (grp_clr & grp_act);
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prev_act_q  <= '0;
      prev_stat_q <= '0;
    end else begin
      prev_act_q  <= act;
      prev_stat_q <= stat_q;
    end
  end

  // pending message vectors, issued lowest first one per cycle
  logic [15:0] pend_q;
  logic        sum_chg;
  assign sum_chg = (sum_d != sum_q) && (sum_d != 32'h0);
  logic [15:0] pend_d;
  logic [3:0]  pick;
  logic        have;
  always_comb begin
    pick = 4'h0;
    have = 1'b0;
    for (int i = 15; i >= 0; i--)
      if (pend_q[i]) begin
        pick = 4'(i);
        have = 1'b1;
      end
    // retire the issued vector first so a same-cycle trigger survives
    pend_d = pend_q;
    if (have) pend_d[pick] = 1'b0;
    if (mode == SHTI_MODE_MULTI) pend_d = pend_d | msg_trig;
    else if (mode == SHTI_MODE_SINGLE && sum_chg) pend_d[0] = 1'b1;
    if (!gie_q) pend_d = 16'h0;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) pend_q <= 16'h0;
    else         pend_q <= pend_d;
  end

  // outputs to the pci side, all registered
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_int_line_n <= 1'b1;
      o_msi        <= '0;
    end else begin
      o_int_line_n <= !(gie_q && mode == SHTI_MODE_WIRE && |sum_q);
      o_msi.valid  <= have && gie_q && mode != SHTI_MODE_WIRE;
      o_msi.vector <= pick;
    end
  end

  // read channel
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `SHTI_OFF_GHC: begin
        rd_val[`SHTI_GLOBAL_INT_ENABLE]   = gie_q;
        rd_val[`SHTI_MSI_REVERT_SINGLE_FLAG] = mrsm;
      end
      `SHTI_OFF_SUMMARY: rd_val = sum_q;
      `SHTI_OFF_MSICFG: begin
        rd_val[`SHTI_MC_MSIE]        = msie_q;
        rd_val[`SHTI_MC_MMC_LSB +: 3] = MMC;
        rd_val[`SHTI_MC_MME_LSB +: 3] = mme_q;
      end
      `SHTI_OFF_PSTAT: rd_val[7:0] = (psel_q < 5'(NPORTS)) ?
                         stat_q[int'(psel_q)*8 +: 8] : 8'h00;
      `SHTI_OFF_PEN:   rd_val[7:0] = (psel_q < 5'(NPORTS)) ?
                         en_q[int'(psel_q)*8 +: 8] : 8'h00;
      `SHTI_OFF_PSEL:  rd_val[4:0] = psel_q;
      `SHTI_OFF_MSIST: rd_val[15:0] = pend_q;
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `SHTI_RST_WORD;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  gie_gates_line_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !gie_q |=> o_int_line_n) else $error("line active while disabled");
  gie_gates_msg_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !gie_q |=> !o_msi.valid) else $error("message while disabled");
  stat_sets_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_port_event[16] |=> stat_q[16]) else $error("status event lost");
  wire_sets_sum_a: assert property (@(posedge i_clk) disable iff (i_reset)
    vwire[2] && IMPL[2] |=> sum_q[2]) else $error("summary not set");
  sum_sticky_a: assert property (@(posedge i_clk) disable iff (i_reset)
    sum_q[2] && !(wr_fire && awaddr_q == `SHTI_OFF_SUMMARY) |=> sum_q[2])
    else $error("summary bit dropped");
  unimpl_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (sum_q & ~IMPL) == 32'h0) else $error("unimplemented bit set");
  line_follows_a: assert property (@(posedge i_clk) disable iff (i_reset)
    gie_q && !msie_q && |sum_q |=> !o_int_line_n)
    else $error("line not active");
  single_msg_a: assert property (@(posedge i_clk) disable iff (i_reset)
    gie_q && mode == SHTI_MODE_SINGLE && sum_chg ##1 gie_q |=> o_msi.valid)
    else $error("single message missing");
endmodule // shti_irq
`default_nettype wire

// ---- inc/shti_cfg.svh ----
`ifndef SHTI_CFG_SVH
`define SHTI_CFG_SVH
// register byte offsets
`define SHTI_OFF_GHC     8'h00
`define SHTI_OFF_SUMMARY 8'h04
`define SHTI_OFF_MSICFG  8'h08
`define SHTI_OFF_PSTAT   8'h0C
`define SHTI_OFF_PEN     8'h10
`define SHTI_OFF_PSEL    8'h14
`define SHTI_OFF_MSIST   8'h18
// field positions
`define SHTI_GLOBAL_INT_ENABLE      0
`define SHTI_MSI_REVERT_SINGLE_FLAG    1
`define SHTI_MC_MSIE     0
`define SHTI_MC_MME_LSB  4
`define SHTI_MC_MMC_LSB  1
// reset values and size limits
`define SHTI_RST_WORD    32'h0000_0000
`define SHTI_RST_MME     3'h0
`define SHTI_MAX_MSGS    16
`define SHTI_SUM_BITS    32
`endif

// ---- inc/shti_pkg.sv ----
package shti_pkg;
  typedef enum logic [1:0] {
    SHTI_MODE_WIRE   = 2'b00,
    SHTI_MODE_SINGLE = 2'b01,
    SHTI_MODE_MULTI  = 2'b10
  } shti_mode_t;
  // one message request toward the pci side
  typedef struct packed {
    logic       valid;
    logic [3:0] vector;
  } shti_msg_t;
endpackage

// ---- testbench/shti_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module shti_host_model
  import shti_pkg::*;
(
  // clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_reset,
  // messages arriving from the adapter
  input  wire shti_msg_t i_msi,
  // tally for the bench
  output logic [7:0]     o_msg_count,
  output logic [3:0]     o_last_vector
);
  // host takes every message at once; no back-pressure exists on msi
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_msg_count   <= 8'h00;
      o_last_vector <= 4'h0;
    end else if (i_msi.valid) begin
      o_msg_count   <= o_msg_count + 8'h01;
      o_last_vector <= i_msi.vector;
    end
  end
endmodule // shti_host_model
`default_nettype wire

// ---- testbench/shti_irq_bench.sv ----
`include "shti_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module shti_irq_bench
  import shti_pkg::*;
;
  // drive, bus and observed signals
  logic        i_clk, i_reset, aw_v, aw_r, w_v, w_r, b_v, b_rdy;
  logic        ar_v, ar_r, r_v, r_rdy, line_n;
  logic [47:0] i_port_event;
  logic [7:0]  aw_a, ar_a, msg_count, cnt0;
  logic [31:0] w_d, r_d, rd_q;
  logic [3:0]  w_s, last_vector;
  logic [1:0]  b_resp, r_resp, wr_resp;
  shti_msg_t   msi;
  int          fails, compares;

  shti_irq dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_port_event(i_port_event), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
    .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_rdy), .o_int_line_n(line_n), .o_msi(msi));
  shti_host_model host (.i_clk(i_clk), .i_reset(i_reset), .i_msi(msi),
    .o_msg_count(msg_count), .o_last_vector(last_vector));

  // free-running clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic give_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (aw_r && aw_v) aw_v <= 1'b0;
      if (w_r && w_v) w_v <= 1'b0;
    end while (b_v !== 1'b1 && n < 100);
    wr_resp = b_resp;
    if (n >= 100) fails++;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    ar_a <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (ar_r && ar_v) ar_v <= 1'b0;
    end while (r_v !== 1'b1 && n < 100);
    rd_q = r_d;
    if (n >= 100) fails++;
  endtask

  task automatic evt(input int p, input int k);
    i_port_event[p*8+k] <= 1'b1;
    @(posedge i_clk);
    i_port_event <= 48'h0;
  endtask

  // two reads give messages and the line time to land
  task automatic chk_sum(input logic [31:0] exp);
    rd(`SHTI_OFF_SUMMARY);
    rd(`SHTI_OFF_SUMMARY);
    chk(rd_q, exp);
  endtask

  task automatic msgs(input logic [7:0] d);
    chk({24'h0, msg_count}, {24'h0, cnt0 + d});
  endtask

  task automatic t_reset;
    rd(`SHTI_OFF_MSICFG);
    chk(rd_q, 32'h0000_0006);
    rd(8'hFC);
    chk({30'h0, r_resp}, 32'h0000_0002);
    chk(rd_q, 32'h0000_0000);
    chk({31'h0, line_n}, 32'h0000_0001);
    wr(8'hFC, 32'h1);
    chk({30'h0, wr_resp}, 32'h0000_0002);
  endtask

  task automatic t_masked;
    wr(`SHTI_OFF_PSEL, 32'h1);
    chk({30'h0, wr_resp}, 32'h0000_0000);
    evt(1, 1);
    rd(`SHTI_OFF_PSTAT);
    chk(rd_q, 32'h0000_0002);
    chk_sum(32'h0000_0000);
    wr(`SHTI_OFF_PSEL, 32'h2);
    wr(`SHTI_OFF_PEN, 32'h1);
    evt(2, 0);
    chk_sum(32'h0000_0004);
    chk({31'h0, line_n}, 32'h0000_0001);
    chk({24'h0, msg_count}, 32'h0000_0000);
  endtask

  task automatic t_wire;
    wr(`SHTI_OFF_GHC, 32'h1);
    chk_sum(32'h0000_0004);
    chk({31'h0, line_n}, 32'h0000_0000);
    wr(`SHTI_OFF_SUMMARY, 32'h0);
    chk_sum(32'h0000_0004);
    wr(`SHTI_OFF_SUMMARY, 32'h4);
    chk_sum(32'h0000_0004);
    wr(`SHTI_OFF_PSTAT, 32'hFF);
    wr(`SHTI_OFF_SUMMARY, 32'h4);
    chk_sum(32'h0000_0000);
    chk({31'h0, line_n}, 32'h0000_0001);
  endtask

  task automatic t_single;
    wr(`SHTI_OFF_MSICFG, 32'h1);
    cnt0 = msg_count;
    evt(2, 0);
    chk_sum(32'h0000_0004);
    msgs(8'h01);
    chk({31'h0, line_n}, 32'h0000_0001);
    wr(`SHTI_OFF_PSTAT, 32'hFF);
    cnt0 = msg_count;
    wr(`SHTI_OFF_SUMMARY, 32'h4);
    chk_sum(32'h0000_0000);
    msgs(8'h00);
  endtask

  task automatic t_multi;
    wr(`SHTI_OFF_MSICFG, 32'h31);
    wr(`SHTI_OFF_PSEL, 32'h5);
    wr(`SHTI_OFF_PEN, 32'h1);
    cnt0 = msg_count;
    evt(5, 0);
    chk_sum(32'h0000_0020);
    msgs(8'h01);
    chk({28'h0, last_vector}, 32'h0000_0005);
    cnt0 = msg_count;
    evt(5, 1);
    wr(`SHTI_OFF_PSTAT, 32'h2);
    chk_sum(32'h0000_0020);
    msgs(8'h01);
    wr(`SHTI_OFF_GHC, 32'h0);
    wr(`SHTI_OFF_PEN, 32'h5);
    cnt0 = msg_count;
    evt(5, 2);
    chk_sum(32'h0000_0020);
    msgs(8'h00);
    wr(`SHTI_OFF_PSTAT, 32'hFF);
    wr(`SHTI_OFF_SUMMARY, 32'hFFFF_FFFF);
    wr(`SHTI_OFF_GHC, 32'h1);
  endtask

  task automatic t_share;
    wr(`SHTI_OFF_MSICFG, 32'h21);
    rd(`SHTI_OFF_GHC);
    chk(rd_q, 32'h0000_0001);
    wr(`SHTI_OFF_PSEL, 32'h4);
    wr(`SHTI_OFF_PEN, 32'h0);
    evt(4, 0);
    cnt0 = msg_count;
    wr(`SHTI_OFF_PEN, 32'h1);
    chk_sum(32'h0000_0010);
    msgs(8'h01);
    chk({28'h0, last_vector}, 32'h0000_0003);
    wr(`SHTI_OFF_PSEL, 32'h5);
    wr(`SHTI_OFF_PEN, 32'h1);
    evt(5, 0);
    chk_sum(32'h0000_0030);
    cnt0 = msg_count;
    wr(`SHTI_OFF_PSTAT, 32'hFF);
    chk_sum(32'h0000_0030);
    msgs(8'h01);
    chk({28'h0, last_vector}, 32'h0000_0003);
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  // main sequence; responses always accepted, so ready stays high
  initial begin
    fails = 0;
    compares = 0;
    i_reset = 1'b1;
    i_port_event = 48'h0;
    {aw_v, w_v, ar_v} = 3'h0;
    {b_rdy, r_rdy} = 2'h3;
    aw_a = 8'h00;
    ar_a = 8'h00;
    w_d = 32'h0;
    w_s = 4'hF;
    cnt0 = 8'h00;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_masked();
    t_wire();
    t_single();
    t_multi();
    t_share();
    give_verdict();
  end
endmodule // shti_irq_bench
`default_nettype wire
